// ===== verilog/remote_io_register_handshake.sv
// Remote I/O mapping and remote register command handshake of one axis
`timescale 1ns/1ps

// Overview of operation
// - 16-bit mode: full 16-bit remote input word; code idles the upper byte when axis_mode16 is high
// - 16-bit mode: full 16-bit remote output word; code masks the upper byte when axis_mode16 is high
// - 8-bit mode: only low byte used; code uses the full word when axis_mode16 is low
// - Execute only on trigger rising edge
// - Code selects read, write, monitor, maintenance
// - Write data is little-endian
// - Response: status 15, done 14, code
// - Status 0 normal, 1 abnormal
// - Completion flag rises when command finished
// - Response echoes the received command code
// - Read data returned little-endian
// - Requests in, responses and outputs out
module remote_io_register_handshake
	import remote_io_pkg::*;
#(
	parameter int PARAM_DEPTH = PARAM_DEPTH_DEF
) (
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic                axis_mode16,
	input  wire logic [REMOTE_W-1:0] remote_in_word,
	input  wire logic [REMOTE_W-1:0] request_word,
	input  wire logic [DATA_W-1:0]   request_data,
	input  wire logic                torque_limit_flag,
	input  wire logic                end_flag,
	input  wire logic                move_flag,
	input  wire logic                timing_flag,
	input  wire logic                zone_flag_1,
	input  wire logic                zone_flag_2,
	input  wire logic                zone_flag_3,
	input  wire logic                sequence_busy_flag,
	input  wire logic                alarm_flag,
	input  wire logic                warning_flag,
	input  wire logic                ready_flag,
	input  wire logic                home_position_flag,
	input  wire logic [DATA_W-1:0]   monitor_value,
	output logic                     positive_continuous_run,
	output logic                     negative_continuous_run,
	output logic                     positive_jog,
	output logic                     negative_jog,
	output logic                     sequential_start,
	output logic                     direct_select_0,
	output logic                     direct_select_1,
	output logic                     direct_select_2,
	output logic                     motor_free,
	output logic                     stop_request,
	output logic                     home_request,
	output logic                     start_request,
	output logic                     op_select_0,
	output logic                     op_select_1,
	output logic                     op_select_2,
	output logic [REMOTE_W-1:0]      net_output_word,
	output logic [REMOTE_W-1:0]      response_word,
	output logic [DATA_W-1:0]        response_data,
	output logic [INDEX_W-1:0]       monitor_select,
	output logic                     alarm_reset_pulse
);

	localparam int ADDR_W  = $clog2(PARAM_DEPTH);
	localparam int SYNC_W  = 1 + 2 * REMOTE_W + DATA_W;
	localparam int NBYTES  = DATA_W / BYTE_W;

	// Byte lane k of a bus carries the k-th transmitted byte, least significant first
	function automatic logic [DATA_W-1:0] le_lanes(input logic [DATA_W-1:0] v);
		logic [DATA_W-1:0] r;
		r = '0;
		for (int i = 0; i < NBYTES; i++) begin
			r[BYTE_W*i +: BYTE_W] = v[BYTE_W*i +: BYTE_W];
		end
		return r;
	endfunction : le_lanes

	// Index out of range or unknown maintenance sub-command is abnormal
	function automatic logic cmd_bad(input logic [1:0] cls, input logic [INDEX_W-1:0] idx);
		logic bad;
		bad = 1'b0;
		case (cls)
			CLS_PARAM_READ:  bad = (32'(idx) >= PARAM_DEPTH);
			CLS_PARAM_WRITE: bad = (32'(idx) >= PARAM_DEPTH);
			CLS_MONITOR:     bad = 1'b0;
			CLS_MAINTAIN:    bad = (idx != MAINT_ALARM_RESET);
			default:         bad = 1'b1;
		endcase
		return bad;
	endfunction : cmd_bad

	// Synchronised pin values
	logic [SYNC_W-1:0]   sync_bus;
	logic                mode8;
	logic [REMOTE_W-1:0] remote_in_s;
	logic [REMOTE_W-1:0] request_s;
	logic [DATA_W-1:0]   data_s;

	// Handshake state
	hs_state_e           state;
	logic                trigger_prev;
	logic                execute_trigger;
	logic                trigger_rise;
	logic [CODE_W-1:0]   req_code;
	logic [DATA_W-1:0]   req_value;
	logic [1:0]          req_class;
	logic [INDEX_W-1:0]  req_index;
	logic                req_bad;
	logic                mem_we;
	logic [DATA_W-1:0]   param_rdata;
	logic [REMOTE_W-1:0] status_word;

	// All converter-side inputs cross into the clock domain together
	pin_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.clock  (clock),
		.rst    (rst),
		.pin    ({axis_mode16, remote_in_word, request_word, request_data}),
		.synced (sync_bus)
	);

	assign data_s      = sync_bus[DATA_W-1:0];
	assign request_s   = sync_bus[DATA_W +: REMOTE_W];
	assign remote_in_s = sync_bus[DATA_W + REMOTE_W +: REMOTE_W];
	assign mode8       = sync_bus[SYNC_W-1];

	// Trigger edge detect; a steady level does nothing
	assign execute_trigger = request_s[REQ_TRIGGER_BIT];
	assign trigger_rise    = execute_trigger & ~trigger_prev;

	always_ff @(posedge clock) begin
		if (rst) begin
			trigger_prev <= 1'b0;
		end else begin
			trigger_prev <= execute_trigger;
		end
	end

	// Command decode from the latched code
	assign req_class = req_code[CLASS_MSB:CLASS_LSB];
	assign req_index = req_code[INDEX_W-1:0];
	assign req_bad   = cmd_bad(req_class, req_index);
	assign mem_we    = (state == ST_EXEC) && (req_class == CLS_PARAM_WRITE) && !req_bad;

	param_store #(
		.DEPTH  (PARAM_DEPTH),
		.DATA_W (DATA_W)
	) u_params (
		.clock      (clock),
		.write_en   (mem_we),
		.addr       (req_index[ADDR_W-1:0]),
		.write_data (req_value),
		.read_data  (param_rdata)
	);

	// Handshake: latch on edge, execute, capture, hold until trigger drops
	always_ff @(posedge clock) begin
		if (rst) begin
			state         <= ST_IDLE;
			req_code      <= '0;
			req_value     <= '0;
			response_word <= '0;
			response_data <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (trigger_rise) begin
						req_code  <= request_s[CODE_W-1:0];
						req_value <= le_lanes(data_s);
						state     <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					state <= ST_CAPTURE;
				end
				ST_CAPTURE: begin
					// Status, completion and echoed code in one word
					response_word[RESP_STATUS_BIT] <= req_bad;
					response_word[RESP_DONE_BIT]   <= 1'b1;
					response_word[CODE_W-1:0]      <= req_code;
					if (req_bad) begin
						response_data <= '0;
					end else if (req_class == CLS_PARAM_READ) begin
						response_data <= le_lanes(param_rdata);
					end else if (req_class == CLS_MONITOR) begin
						response_data <= le_lanes(monitor_value);
					end else begin
						response_data <= '0;
					end
					state <= ST_DONE;
				end
				ST_DONE: begin
					// Waiting for the converter to drop its trigger
					if (!execute_trigger) begin
						response_word[RESP_DONE_BIT] <= 1'b0;
						state                        <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Monitor selector follows the latest request so the source can settle
	always_ff @(posedge clock) begin
		if (rst) begin
			monitor_select <= '0;
		end else if (state == ST_IDLE && trigger_rise) begin
			monitor_select <= request_s[INDEX_W-1:0];
		end
	end

	// Maintenance action pulses once per accepted command
	always_ff @(posedge clock) begin
		if (rst) begin
			alarm_reset_pulse <= 1'b0;
		end else begin
			alarm_reset_pulse <= (state == ST_EXEC) && (req_class == CLS_MAINTAIN) && !req_bad;
		end
	end

	// Remote input word to control signals; upper byte idle when axis_mode16 is high
	always_ff @(posedge clock) begin
		if (rst) begin
			positive_continuous_run <= 1'b0;
			negative_continuous_run <= 1'b0;
			positive_jog            <= 1'b0;
			negative_jog            <= 1'b0;
			sequential_start        <= 1'b0;
			direct_select_0         <= 1'b0;
			direct_select_1         <= 1'b0;
			direct_select_2         <= 1'b0;
			motor_free              <= 1'b0;
			stop_request            <= 1'b0;
			home_request            <= 1'b0;
			start_request           <= 1'b0;
			op_select_0             <= 1'b0;
			op_select_1             <= 1'b0;
			op_select_2             <= 1'b0;
		end else begin
			positive_continuous_run <= !mode8 && remote_in_s[IN_POS_RUN];
			negative_continuous_run <= !mode8 && remote_in_s[IN_NEG_RUN];
			positive_jog            <= !mode8 && remote_in_s[IN_POS_JOG];
			negative_jog            <= !mode8 && remote_in_s[IN_NEG_JOG];
			sequential_start        <= !mode8 && remote_in_s[IN_SEQ_START];
			direct_select_0         <= !mode8 && remote_in_s[IN_DIR_SEL_0];
			direct_select_1         <= !mode8 && remote_in_s[IN_DIR_SEL_1];
			direct_select_2         <= !mode8 && remote_in_s[IN_DIR_SEL_2];
			motor_free              <= remote_in_s[IN_FREE];
			stop_request            <= remote_in_s[IN_STOP];
			home_request            <= remote_in_s[IN_HOME];
			start_request           <= remote_in_s[IN_START];
			op_select_0             <= remote_in_s[IN_OP_SEL_0];
			op_select_1             <= remote_in_s[IN_OP_SEL_1];
			op_select_2             <= remote_in_s[IN_OP_SEL_2];
		end
	end

	// Status flags and echoes gathered into the remote output layout
	always_comb begin
		status_word                 = '0;
		status_word[OUT_TORQUE]     = torque_limit_flag;
		status_word[OUT_END]        = end_flag;
		status_word[OUT_MOVE]       = move_flag;
		status_word[OUT_TIMING]     = timing_flag;
		status_word[OUT_ZONE_3]     = zone_flag_3;
		status_word[OUT_ZONE_2]     = zone_flag_2;
		status_word[OUT_ZONE_1]     = zone_flag_1;
		status_word[OUT_SEQ_BUSY]   = sequence_busy_flag;
		status_word[OUT_ALARM]      = alarm_flag;
		status_word[OUT_WARNING]    = warning_flag;
		status_word[OUT_READY]      = ready_flag;
		status_word[OUT_HOME_POS]   = home_position_flag;
		status_word[OUT_START_ECHO] = start_request;
		status_word[OUT_OP_ECHO_2]  = op_select_2;
		status_word[OUT_OP_ECHO_1]  = op_select_1;
		status_word[OUT_OP_ECHO_0]  = op_select_0;
	end

	// Registered so the converter never sees a mid-update mix of flags
	always_ff @(posedge clock) begin
		if (rst) begin
			net_output_word <= '0;
		end else if (mode8) begin
			net_output_word <= status_word & LOW_BYTE_MASK;
		end else begin
			net_output_word <= status_word;
		end
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence seq_request;
		state == ST_IDLE && trigger_rise;
	endsequence

	sequence seq_finished;
		##3 response_word[RESP_DONE_BIT] && state == ST_DONE;
	endsequence

	chk_exec_on_edge: assert property (seq_request |-> seq_finished)
		else $error("completion did not follow trigger edge in three cycles");

	chk_steady_idle: assert property (state == ST_IDLE && !trigger_rise |=> state == ST_IDLE)
		else $error("handshake left idle without a trigger edge");

	chk_code_echo: assert property ($rose(response_word[RESP_DONE_BIT])
		|-> response_word[CODE_W-1:0] == req_code)
		else $error("response code differs from request code");

	chk_status_value: assert property (state == ST_CAPTURE
		|=> response_word[RESP_STATUS_BIT] == $past(req_bad))
		else $error("result status does not match command validity");

	chk_flag_hold: assert property (state == ST_DONE && execute_trigger
		|=> response_word[RESP_DONE_BIT])
		else $error("completion flag dropped while trigger high");

	chk_flag_clear: assert property (state == ST_DONE && !execute_trigger
		|=> !response_word[RESP_DONE_BIT] ##1 !response_word[RESP_DONE_BIT])
		else $error("completion flag not cleared after trigger low");

	chk_read_order: assert property (state == ST_CAPTURE && req_class == CLS_PARAM_READ
		&& !req_bad |=> response_data == le_lanes($past(param_rdata)))
		else $error("read data not returned from parameter store");

	chk_upper_idle: assert property (mode8
		|=> (net_output_word & ~LOW_BYTE_MASK) == '0 && !positive_continuous_run)
		else $error("upper byte active in 8-bit mode");

	chk_input_map: assert property (!mode8
		|=> negative_continuous_run == $past(remote_in_s[IN_NEG_RUN])
		&& start_request == $past(remote_in_s[IN_START]))
		else $error("remote input bit mapping wrong");

	chk_output_map: assert property (!mode8
		|=> net_output_word[OUT_TORQUE] == $past(torque_limit_flag)
		&& net_output_word[OUT_ALARM] == $past(alarm_flag))
		else $error("remote output bit mapping wrong");

	chk_maint_pulse: assert property (state == ST_EXEC && req_class == CLS_MAINTAIN
		&& !req_bad |=> alarm_reset_pulse ##1 !alarm_reset_pulse)
		else $error("maintenance command did not pulse once");

endmodule : remote_io_register_handshake

// ===== pkg/remote_io_pkg.sv
// Constants shared by the remote I/O and remote register handshake block
package remote_io_pkg;

	// Word widths
	localparam int REMOTE_W = 16;
	localparam int CODE_W   = 14;
	localparam int DATA_W   = 32;
	localparam int BYTE_W   = 8;
	localparam int INDEX_W  = 12;

	// Request and response word fields
	localparam int REQ_TRIGGER_BIT = 14;
	localparam int RESP_STATUS_BIT = 15;
	localparam int RESP_DONE_BIT   = 14;
	localparam int CLASS_LSB       = 12;
	localparam int CLASS_MSB       = 13;

	// Command classes held in the code's top two bits
	localparam logic [1:0] CLS_PARAM_READ  = 2'h0;
	localparam logic [1:0] CLS_PARAM_WRITE = 2'h1;
	localparam logic [1:0] CLS_MONITOR     = 2'h2;
	localparam logic [1:0] CLS_MAINTAIN    = 2'h3;

	// Maintenance sub-commands
	localparam logic [INDEX_W-1:0] MAINT_ALARM_RESET = 12'h000;

	// Parameter store defaults
	localparam int PARAM_DEPTH_DEF = 256;

	// Mask keeping the low byte when axis_mode16 is high
	localparam logic [REMOTE_W-1:0] LOW_BYTE_MASK = 16'h00FF;

	// Remote input bit positions
	localparam int IN_OP_SEL_0   = 0;
	localparam int IN_OP_SEL_1   = 1;
	localparam int IN_OP_SEL_2   = 2;
	localparam int IN_START      = 3;
	localparam int IN_HOME       = 4;
	localparam int IN_STOP       = 5;
	localparam int IN_FREE       = 6;
	localparam int IN_DIR_SEL_0  = 8;
	localparam int IN_DIR_SEL_1  = 9;
	localparam int IN_DIR_SEL_2  = 10;
	localparam int IN_SEQ_START  = 11;
	localparam int IN_POS_JOG    = 12;
	localparam int IN_NEG_JOG    = 13;
	localparam int IN_POS_RUN    = 14;
	localparam int IN_NEG_RUN    = 15;

	// Remote output bit positions
	localparam int OUT_OP_ECHO_0 = 0;
	localparam int OUT_OP_ECHO_1 = 1;
	localparam int OUT_OP_ECHO_2 = 2;
	localparam int OUT_START_ECHO = 3;
	localparam int OUT_HOME_POS  = 4;
	localparam int OUT_READY     = 5;
	localparam int OUT_WARNING   = 6;
	localparam int OUT_ALARM     = 7;
	localparam int OUT_SEQ_BUSY  = 8;
	localparam int OUT_ZONE_1    = 9;
	localparam int OUT_ZONE_2    = 10;
	localparam int OUT_ZONE_3    = 11;
	localparam int OUT_TIMING    = 12;
	localparam int OUT_MOVE      = 13;
	localparam int OUT_END       = 14;
	localparam int OUT_TORQUE    = 15;

	// Handshake states, Gray coded along the path
	typedef enum logic [1:0] {
		ST_IDLE    = 2'h0,
		ST_EXEC    = 2'h1,
		ST_CAPTURE = 2'h3,
		ST_DONE    = 2'h2
	} hs_state_e;

endpackage : remote_io_pkg

// ===== verilog/pin_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] synced
);

	logic [WIDTH-1:0] stage;

	// First stage feeds only the second
	always_ff @(posedge clock) begin
		if (rst) begin
			stage  <= '0;
			synced <= '0;
		end else begin
			stage  <= pin;
			synced <= stage;
		end
	end

endmodule : pin_sync

// ===== verilog/param_store.sv
// Parameter memory with registered read data
`timescale 1ns/1ps
module param_store #(
	parameter int DEPTH  = 256,
	parameter int DATA_W = 32,
	parameter int ADDR_W = $clog2(DEPTH)
) (
	input  wire logic              clock,
	input  wire logic              write_en,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] write_data,
	output logic      [DATA_W-1:0] read_data
);

	logic [DATA_W-1:0] cells [DEPTH];

	// Read-before-write, one cycle latency
	always_ff @(posedge clock) begin
		if (write_en) begin
			cells[addr] <= write_data;
		end
		read_data <= cells[addr];
	end

endmodule : param_store

// ===== sim/converter_model.sv
// Network converter model driving the remote register request side
`timescale 1ns/1ps
module converter_model
	import remote_io_pkg::*;
(
	input  wire logic                clock,
	input  wire logic [REMOTE_W-1:0] response_word,
	input  wire logic [DATA_W-1:0]   response_data,
	output logic      [REMOTE_W-1:0] request_word,
	output logic      [DATA_W-1:0]   request_data
);
	// Idle request at time zero, trigger low
	initial begin
		request_word = 16'h0000;
		request_data = 32'h00000000;
	end

	// One command: code and data settle first, then trigger, wait, drop
	task automatic run(
		input  logic [CODE_W-1:0]   code,
		input  logic [DATA_W-1:0]   data,
		output logic [REMOTE_W-1:0] resp,
		output logic [DATA_W-1:0]   rdata,
		output bit                  ok
	);
		int n;
		n = 0;
		request_word <= {2'h0, code};
		request_data <= data;
		repeat (3) @(posedge clock);
		request_word[REQ_TRIGGER_BIT] <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (response_word[RESP_DONE_BIT] !== 1'b1 && n < 20);
		resp  = response_word;
		rdata = response_data;
		// Data is no longer held, so scramble it to expose late sampling
		request_word[REQ_TRIGGER_BIT] <= 1'b0;
		request_data <= ~data;
		ok = (n < 20);
		n  = 0;
		do begin
			@(posedge clock);
			n++;
		end while (response_word[RESP_DONE_BIT] !== 1'b0 && n < 20);
		ok = ok && (n < 20);
	endtask : run

	// Code and data only, trigger left low; the device must ignore it
	task automatic present(
		input logic [CODE_W-1:0] code,
		input logic [DATA_W-1:0] data
	);
		request_word <= {2'h0, code};
		request_data <= data;
	endtask : present
endmodule : converter_model

// ===== sim/remote_io_register_handshake_tb.sv
// Self-checking bench for the remote I/O and register handshake block
`timescale 1ns/1ps
module remote_io_register_handshake_tb;
	import remote_io_pkg::*;

	logic                clock          = 1'b0;
	logic                rst            = 1'b1;
	logic                axis_mode16    = 1'b0;
	logic [REMOTE_W-1:0] remote_in_word = 16'h0000;
	logic [11:0]         st             = 12'h000;
	logic [DATA_W-1:0]   monitor_value  = 32'h00000000;
	logic [REMOTE_W-1:0] request_word;
	logic [REMOTE_W-1:0] net_output_word;
	logic [REMOTE_W-1:0] response_word;
	logic [DATA_W-1:0]   request_data;
	logic [DATA_W-1:0]   response_data;
	wire  [14:0]         ctrl;
	logic [INDEX_W-1:0]  monitor_select;
	logic                alarm_reset_pulse;
	logic [DATA_W-1:0]   mem [0:7];
	logic [INDEX_W-1:0]  idx [0:7];
	logic [DATA_W-1:0]   mv;
	int                  mismatches = 0;
	int                  checks     = 0;
	int                  pulses     = 0;

	// 20 MHz clock
	always #25 clock = ~clock;

	remote_io_register_handshake remote_io_register_handshake_inst (
		.clock(clock), .rst(rst), .axis_mode16(axis_mode16),
		.remote_in_word(remote_in_word), .request_word(request_word),
		.request_data(request_data), .torque_limit_flag(st[11]), .end_flag(st[10]),
		.move_flag(st[9]), .timing_flag(st[8]), .zone_flag_3(st[7]), .zone_flag_2(st[6]),
		.zone_flag_1(st[5]), .sequence_busy_flag(st[4]), .alarm_flag(st[3]),
		.warning_flag(st[2]), .ready_flag(st[1]), .home_position_flag(st[0]),
		.monitor_value(monitor_value), .positive_continuous_run(ctrl[14]),
		.negative_continuous_run(ctrl[13]), .positive_jog(ctrl[12]), .negative_jog(ctrl[11]),
		.sequential_start(ctrl[10]), .direct_select_0(ctrl[9]), .direct_select_1(ctrl[8]),
		.direct_select_2(ctrl[7]), .motor_free(ctrl[6]), .stop_request(ctrl[5]),
		.home_request(ctrl[4]), .start_request(ctrl[3]), .op_select_0(ctrl[2]),
		.op_select_1(ctrl[1]), .op_select_2(ctrl[0]), .net_output_word(net_output_word),
		.response_word(response_word), .response_data(response_data),
		.monitor_select(monitor_select), .alarm_reset_pulse(alarm_reset_pulse)
	);

	converter_model conv_inst (
		.clock(clock), .response_word(response_word), .response_data(response_data),
		.request_word(request_word), .request_data(request_data)
	);

	// Count alarm reset strobes
	always @(posedge clock) if (alarm_reset_pulse === 1'b1) pulses++;

	// Control outputs in the ctrl packing order; upper byte dead when m16 is set
	function automatic logic [14:0] exp_ctrl(input logic [15:0] w, input logic m16);
		logic [7:0] h;
		h = m16 ? 8'h00 : w[15:8];
		return {h[6], h[7], h[4], h[5], h[3], h[0], h[1], h[2],
			w[6], w[5], w[4], w[3], w[0], w[1], w[2]};
	endfunction : exp_ctrl

	function automatic logic [15:0] exp_out(input logic [11:0] s, input logic [15:0] w,
		input logic m16);
		return {m16 ? 8'h00 : s[11:4], s[3:0], w[3], w[2:0]};
	endfunction : exp_out

	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Random and all-ones words through both directions of remote I/O
	task automatic io_test(input logic m16);
		logic [15:0] w;
		for (int i = 0; i < 24; i++) begin
			w = (i == 0) ? 16'hFFFF : 16'($urandom);
			@(posedge clock);
			axis_mode16    <= m16;
			remote_in_word <= w;
			st             <= (i == 0) ? 12'hFFF : 12'($urandom);
			repeat (6) @(posedge clock);
			@(negedge clock);
			check(32'(ctrl), 32'(exp_ctrl(w, m16)));
			check(32'(net_output_word), 32'(exp_out(st, w, m16)));
		end
		$display("Remote I/O test done, mode16=%0d", m16);
	endtask : io_test

	task automatic cmd(input logic [1:0] cls, input logic [INDEX_W-1:0] ix,
		input logic [DATA_W-1:0] d, input logic bad, input logic [DATA_W-1:0] ed);
		logic [REMOTE_W-1:0] r;
		logic [DATA_W-1:0]   rd;
		bit                  ok;
		@(posedge clock);
		conv_inst.run({cls, ix}, d, r, rd, ok);
		check(32'(ok), 32'h1);
		check(32'(r), 32'({bad, 1'b1, cls, ix}));
		check(rd, ed);
	endtask : cmd

	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	// Watchdog, far beyond the expected run of under two thousand cycles
	initial begin
		#(50 * 20000);
		mismatches++;
		end_of_test;
	end

	initial begin
		void'($urandom(32'h23D1));
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		io_test(1'b0);
		io_test(1'b1);
		// Distinct indices so read-backs cannot alias; top index 255 included
		for (int i = 0; i < 8; i++) begin
			idx[i] = 12'(i * 32 + ((i == 7) ? 31 : $urandom_range(0, 31)));
			mem[i] = $urandom;
			cmd(CLS_PARAM_WRITE, idx[i], mem[i], 1'b0, 32'h0);
		end
		for (int i = 7; i >= 0; i--) cmd(CLS_PARAM_READ, idx[i], 32'h0, 1'b0, mem[i]);
		// New write code with trigger low must do nothing
		@(posedge clock);
		conv_inst.present({CLS_PARAM_WRITE, idx[0]}, ~mem[0]);
		repeat (10) @(posedge clock);
		check(32'(response_word[RESP_DONE_BIT]), 32'h0);
		cmd(CLS_PARAM_READ, idx[0], 32'h0, 1'b0, mem[0]);
		cmd(CLS_PARAM_READ, 12'h100, 32'h0, 1'b1, 32'h0);
		cmd(CLS_PARAM_WRITE, 12'hFFF, 32'h5A, 1'b1, 32'h0);
		cmd(CLS_MAINTAIN, MAINT_ALARM_RESET, 32'h0, 1'b0, 32'h0);
		check(32'(pulses), 32'h1);
		cmd(CLS_MAINTAIN, 12'h001, 32'h0, 1'b1, 32'h0);
		check(32'(pulses), 32'h1);
		@(posedge clock);
		mv = $urandom;
		monitor_value <= mv;
		cmd(CLS_MONITOR, 12'h007, 32'h0, 1'b0, mv);
		check(32'(monitor_select), 32'h7);
		$display("Register tests done");
		end_of_test;
	end
endmodule : remote_io_register_handshake_tb
